// *** core/rpic_top.sv ***
`timescale 1ns/10ps
`include "rpic_regs.svh"
module rpic_top (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`RPIC_NUM_CAUSE-1:0] cause_in,
    input wire logic [31:0] addr,
    input wire rpic_pkg::rpic_word_t wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output rpic_pkg::rpic_word_t rd_data,
    output logic fast_req,
    output logic normal_req
);
    import rpic_pkg::*;

    logic [`RPIC_NUM_CAUSE-1:0] cause_sync;
    rpic_word_t req_v;
    rpic_word_t latch_r, latch_nxt;
    rpic_word_t mode_r;
    rpic_word_t mask_r;
    rpic_word_t wpend_r, wpend_nxt;
    rpic_src_t widx_r;
    logic [`RPIC_NUM_ARB-1:0] rot_r;
    logic [2*`RPIC_NUM_ARB-1:0] sel_r, sel_nxt;
    rpic_word_t rd_data_r;
    logic fast_r, norm_r;
    rpic_word_t elig;
    logic [5:0] l1_valid;
    rpic_in_t l1_win [6];
    rpic_sel_t arb_snxt [`RPIC_NUM_ARB];
    logic l2_valid;
    rpic_in_t l2_win;
    rpic_src_t win_src;
    logic set_win;
    logic wr_latch, wr_mode, wr_mask, wr_prio, wr_wpend;
    rpic_word_t rd_mux;
    localparam logic [`RPIC_CNT_W*32-1:0] CNT_TBL = `RPIC_CAUSE_CNT;

    // Index of the first cause belonging to a request line
    function automatic int cause_base(input int line);
        int b;
        b = 0;
        for (int j = 0; j < line; j++)
        begin
            b = b + int'(CNT_TBL[`RPIC_CNT_W*j +: `RPIC_CNT_W]);
        end
        return b;
    endfunction

    // Causes come from other logic or pins; synchronise before use
    rpic_sync #(.WIDTH(`RPIC_NUM_CAUSE)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .d(cause_in),
        .q(cause_sync)
    );

    // Grouped causes ORed onto shared lines; reserved lines tied low
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_line
            localparam int CNT = int'(CNT_TBL[`RPIC_CNT_W*i +: `RPIC_CNT_W]);
            localparam int BASE = cause_base(i);
            if (CNT == 0)
            begin : g_rsv
                assign req_v[i] = 1'b0;
            end
            else
            begin : g_or
                assign req_v[i] = |cause_sync[BASE +: CNT];
            end
        end
    endgenerate

    // Bus decode
    assign wr_latch = wr_en && addr == `RPIC_ADR_LATCH;
    assign wr_mode = wr_en && addr == `RPIC_ADR_MODE;
    assign wr_mask = wr_en && addr == `RPIC_ADR_MASK;
    assign wr_prio = wr_en && addr == `RPIC_ADR_PRIO;
    assign wr_wpend = wr_en && addr == `RPIC_ADR_WPEND;

    // Only unmasked normal-mode latched bits compete
    assign elig = latch_r & ~mask_r & ~mode_r;

    // First level: groups 0 and 5 hold four sources on inputs 1..4
    generate
        for (i = 0; i < 6; i++)
        begin : g_l1
            logic [5:0] grp_req;
            if (i == 0)
            begin : g_lo
                assign grp_req = {1'b0, elig[3:0], 1'b0};
            end
            else if (i == 5)
            begin : g_hi
                assign grp_req = {1'b0, elig[`RPIC_TOP_BASE +: 4], 1'b0};
            end
            else
            begin : g_mid
                assign grp_req = elig[`RPIC_MID_BASE + `RPIC_GRP_W*(i-1) +: `RPIC_GRP_W];
            end
            rpic_arb6 u_arb (
                .req(grp_req),
                .sel(rpic_sel_t'(sel_r[2*i +: 2])),
                .valid(l1_valid[i]),
                .win(l1_win[i]),
                .sel_nxt(arb_snxt[i])
            );
        end
    endgenerate

    // Second level takes group winners, group 0 on input 0
    rpic_arb6 u_arb_l2 (
        .req(l1_valid),
        .sel(rpic_sel_t'(sel_r[2*`RPIC_L2 +: 2])),
        .valid(l2_valid),
        .win(l2_win),
        .sel_nxt(arb_snxt[`RPIC_L2])
    );

    // Source number of the overall winner
    always_comb
    begin
        rpic_in_t w;
        w = l1_win[l2_win];
        if (l2_win == `RPIC_IN_FIRST)
        begin
            win_src = 5'(w - `RPIC_IN_ONE);
        end
        else if (l2_win == `RPIC_IN_LAST)
        begin
            win_src = 5'(`RPIC_TOP_BASE + int'(w) - 1);
        end
        else
        begin
            win_src = 5'(`RPIC_MID_BASE + `RPIC_GRP_W * (int'(l2_win) - 1) + int'(w));
        end
    end

    // Arbitrate only while no winner is outstanding
    assign set_win = ~|wpend_r && l2_valid;

    // New requests win over a same-cycle clear
    assign latch_nxt = (latch_r & ~(wr_latch ? wr_data : `RPIC_ZERO32)) | req_v;

    // Exactly one winner bit; cleared by writing ones
    assign wpend_nxt = set_win ? (32'h00000001 << win_src)
        : wpend_r & ~(wr_wpend ? wr_data : `RPIC_ZERO32);

    // Order selects: software write first, else rotation on a new winner
    generate
        for (i = 0; i < `RPIC_NUM_ARB; i++)
        begin : g_sel
            logic hit;
            assign hit = set_win && rot_r[i] && (i == `RPIC_L2 || l2_win == 3'(i));
            assign sel_nxt[2*i +: 2] = wr_prio ? wr_data[`RPIC_PRI_SEL_LSB + 2*i +: 2]
                : hit ? 2'(arb_snxt[i]) : sel_r[2*i +: 2];
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    assign rd_mux = (addr == `RPIC_ADR_LATCH) ? latch_r
        : (addr == `RPIC_ADR_MODE) ? mode_r
        : (addr == `RPIC_ADR_MASK) ? mask_r
        : (addr == `RPIC_ADR_PRIO) ? {11'h000, sel_r, rot_r}
        : (addr == `RPIC_ADR_WPEND) ? wpend_r
        : (addr == `RPIC_ADR_WIDX) ? {27'h0000000, widx_r}
        : `RPIC_ZERO32;

    // Pending state
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            latch_r <= `RPIC_ZERO32;
            wpend_r <= `RPIC_ZERO32;
            widx_r <= 5'h00;
        end
        else if (ce)
        begin
            latch_r <= latch_nxt;
            wpend_r <= wpend_nxt;
            if (set_win)
            begin
                widx_r <= win_src;
            end
        end
    end

    // Configuration; everything starts masked
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= `RPIC_ZERO32;
            mask_r <= `RPIC_MASK_RST;
            rot_r <= 7'h00;
            sel_r <= 14'h0000;
        end
        else if (ce)
        begin
            if (wr_mode)
            begin
                mode_r <= wr_data;
            end
            if (wr_mask)
            begin
                mask_r <= wr_data;
            end
            if (wr_prio)
            begin
                rot_r <= wr_data[`RPIC_PRI_ROT_LSB +: `RPIC_NUM_ARB];
            end
            sel_r <= sel_nxt;
        end
    end

    // Outputs to the core and the bus, all registered
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fast_r <= 1'b0;
            norm_r <= 1'b0;
            rd_data_r <= `RPIC_ZERO32;
        end
        else if (ce)
        begin
            fast_r <= |(latch_r & mode_r & ~mask_r);
            norm_r <= |wpend_r;
            rd_data_r <= rd_en ? rd_mux : `RPIC_ZERO32;
        end
    end

    assign rd_data = rd_data_r;
    assign fast_req = fast_r;
    assign normal_req = norm_r;

    // Checks
    sequence s_idle_ready;
        ce && wpend_r == `RPIC_ZERO32 && elig != `RPIC_ZERO32;
    endsequence

    sequence s_one_winner;
        $onehot(wpend_r) ##1 (wpend_r == `RPIC_ZERO32 || $onehot(wpend_r));
    endsequence

    property p_latch_set;
        @(posedge mclk) disable iff (rst)
        ce |=> ((latch_r & $past(req_v)) == $past(req_v));
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("request not latched");

    property p_latch_hold;
        @(posedge mclk) disable iff (rst)
        (ce && !wr_latch) |=> (($past(latch_r) & ~latch_r) == `RPIC_ZERO32);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch dropped a bit");

    property p_latch_w1c;
        @(posedge mclk) disable iff (rst)
        (ce && wr_latch) |=> ((latch_r & $past(wr_data)) == ($past(req_v) & $past(wr_data)));
    endproperty
    a_latch_w1c: assert property (p_latch_w1c) else $error("write one did not clear");

    property p_rearm;
        @(posedge mclk) disable iff (rst)
        s_idle_ready |=> s_one_winner;
    endproperty
    a_rearm: assert property (p_rearm) else $error("pending request not serviced");

    property p_onehot;
        @(posedge mclk) disable iff (rst)
        $onehot0(wpend_r);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one winner bit");

    property p_not_masked;
        @(posedge mclk) disable iff (rst)
        (ce && set_win) |=> ((wpend_r & $past(mask_r)) == `RPIC_ZERO32);
    endproperty
    a_not_masked: assert property (p_not_masked) else $error("masked source won");

    property p_not_fast;
        @(posedge mclk) disable iff (rst)
        (ce && set_win) |=> ((wpend_r & $past(mode_r)) == `RPIC_ZERO32 && widx_r == $past(win_src));
    endproperty
    a_not_fast: assert property (p_not_fast) else $error("fast source won");

    property p_fixed_sel;
        @(posedge mclk) disable iff (rst)
        (ce && !wr_prio && !rot_r[`RPIC_L2]) |=> $stable(sel_r[2*`RPIC_L2 +: 2]);
    endproperty
    a_fixed_sel: assert property (p_fixed_sel) else $error("fixed select changed");

    property p_rotate;
        @(posedge mclk) disable iff (rst)
        (ce && !wr_prio && set_win && rot_r[`RPIC_L2] && l2_win != `RPIC_IN_FIRST
            && l2_win != `RPIC_IN_LAST) |=> (sel_r[2*`RPIC_L2 +: 2] == $past(l2_win[1:0]));
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotation select wrong");

    property p_first_wins;
        @(posedge mclk) disable iff (rst)
        l1_valid[0] |-> (l2_win == `RPIC_IN_FIRST);
    endproperty
    a_first_wins: assert property (p_first_wins) else $error("input zero lost");

    property p_fast_out;
        @(posedge mclk) disable iff (rst)
        ce |=> (fast_req == $past(|(latch_r & mode_r & ~mask_r)));
    endproperty
    a_fast_out: assert property (p_fast_out) else $error("fast request wrong");
endmodule

// *** core/rpic_regs.svh ***
// How it works
// - Every requesting source sets its latch bit.
// - Arbitration never alters the request latch.
// - Writing ones clears latch bits; zeros keep.
// - Set latch bit stays a live request.
// - Arbitration sets exactly one winner pending bit.
// - Masked sources latch but never win.
// - Mask one blocks service, zero allows.
// - Route latched requests to fast or normal.
// - Normal requests resolved by arbiter priority settings.
// - Seven arbiters: six first level, one second.
// - Groups take sources in ascending source order.
// - Order select picks one of four orders.
// - Input zero always first, input five last.
// - Rotation off keeps order select unchanged.
// - Rotation on: serviced input sets order select.
// - Fifty-six causes ORed onto request lines.
// - Sources at fixed bits; 24, 6 reserved.
// - Mode one routes fast, zero routes normal.
// - Fast sources never touch winner registers.
// - All mask bits set after reset.
`ifndef RPIC_REGS_SVH
`define RPIC_REGS_SVH

// Register byte addresses
`define RPIC_ADR_LATCH 32'h4A000000
`define RPIC_ADR_MODE 32'h4A000004
`define RPIC_ADR_MASK 32'h4A000008
`define RPIC_ADR_PRIO 32'h4A00000C
`define RPIC_ADR_WPEND 32'h4A000010
`define RPIC_ADR_WIDX 32'h4A000014

// Reset values
`define RPIC_ZERO32 32'h00000000
`define RPIC_MASK_RST 32'hFFFFFFFF

// Priority register layout: rotate enables, then two-bit order selects
`define RPIC_PRI_ROT_LSB 0
`define RPIC_PRI_SEL_LSB 7
`define RPIC_NUM_ARB 7
`define RPIC_L2 6

// Cause inputs and per-line cause counts, line 31 first, 5 bits each
`define RPIC_NUM_CAUSE 56
`define RPIC_CNT_W 5
`define RPIC_CAUSE_CNT {5'h02, 5'h01, 5'h01, 5'h03, 5'h01, 5'h01, 5'h01, 5'h00, \
    5'h03, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h02, \
    5'h03, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, 5'h01, \
    5'h01, 5'h00, 5'h10, 5'h04, 5'h01, 5'h01, 5'h01, 5'h01}

// Group layout
`define RPIC_GRP_W 6
`define RPIC_MID_BASE 4
`define RPIC_TOP_BASE 28
`define RPIC_IN_FIRST 3'h0
`define RPIC_IN_LAST 3'h5
`define RPIC_IN_ONE 3'h1

`endif

// *** core/rpic_pkg.sv ***
package rpic_pkg;
    // Order select codes
    typedef enum logic [1:0] {
        RPIC_ORD_0 = 2'h0,
        RPIC_ORD_1 = 2'h1,
        RPIC_ORD_2 = 2'h2,
        RPIC_ORD_3 = 2'h3
    } rpic_sel_t;
    typedef logic [31:0] rpic_word_t;
    typedef logic [2:0] rpic_in_t;
    typedef logic [4:0] rpic_src_t;
endpackage

// *** core/rpic_sync.sv ***
`timescale 1ns/10ps
module rpic_sync #(
    parameter int WIDTH = 56
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // Two stages; only the second stage is read downstream
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= '0;
            q <= '0;
        end
        else if (ce)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// *** core/rpic_arb6.sv ***
`timescale 1ns/10ps
`include "rpic_regs.svh"
module rpic_arb6 (
    input wire logic [5:0] req,
    input wire rpic_pkg::rpic_sel_t sel,
    output logic valid,
    output rpic_pkg::rpic_in_t win,
    output rpic_pkg::rpic_sel_t sel_nxt
);
    import rpic_pkg::*;

    // Input 0 first, 1..4 rotate from sel, input 5 last
    always_comb
    begin
        logic found;
        rpic_in_t cand;
        found = 1'b0;
        cand = `RPIC_IN_FIRST;
        win = `RPIC_IN_LAST;
        if (req[0])
        begin
            win = `RPIC_IN_FIRST;
        end
        else
        begin
            for (int k = 0; k < 4; k++)
            begin
                cand = {1'b0, 2'(sel + 2'(k))} + `RPIC_IN_ONE;
                if (!found && req[cand])
                begin
                    win = cand;
                    found = 1'b1;
                end
            end
        end
    end

    assign valid = |req;
    // Ends keep the select; inputs 1..4 map to their low bits (4 wraps to 0)
    assign sel_nxt = (win == `RPIC_IN_FIRST || win == `RPIC_IN_LAST) ? sel
        : rpic_sel_t'(win[1:0]);
endmodule

// *** tb/rpic_core_model.sv ***
`timescale 1ns/10ps
module rpic_core_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic fast_req,
    input wire logic normal_req,
    output logic [7:0] fast_cnt,
    output logic [7:0] normal_cnt
);
    logic fast_d_r;
    logic normal_d_r;

    // Count entries only; a held level is one interrupt, not many
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fast_d_r <= 1'b0;
            normal_d_r <= 1'b0;
            fast_cnt <= 8'h00;
            normal_cnt <= 8'h00;
        end
        else
        begin
            fast_d_r <= fast_req;
            normal_d_r <= normal_req;
            if (fast_req && !fast_d_r)
                fast_cnt <= fast_cnt + 8'h01;
            if (normal_req && !normal_d_r)
                normal_cnt <= normal_cnt + 8'h01;
        end
    end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
`include "rpic_regs.svh"
module tb_top;
    import rpic_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [55:0] cause_in = '0;
    logic [31:0] addr = '0;
    rpic_word_t wr_data = '0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    rpic_word_t rd_data;
    logic fast_req;
    logic normal_req;
    logic [7:0] fast_cnt;
    logic [7:0] normal_cnt;
    int error_cnt = 0;
    int num_checks = 0;

    // Free-running system clock
    always #20 mclk = ~mclk;

    rpic_top rpic_top_i (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .cause_in(cause_in),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .fast_req(fast_req),
        .normal_req(normal_req)
    );

    rpic_core_model rpic_core_model_i (
        .mclk(mclk),
        .rst(rst),
        .fast_req(fast_req),
        .normal_req(normal_req),
        .fast_cnt(fast_cnt),
        .normal_cnt(normal_cnt)
    );

    task complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Strobe held over one full edge, dropped right after it
    task wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_en <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task rd(input logic [31:0] a, input logic [31:0] e, input string n);
        @(posedge mclk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        chk(n, rd_data, e);
    endtask

    // Expected winner: input 0 first, 1..4 rotated by select, 5 last
    function automatic int pick(input logic [5:0] r, input logic [1:0] s);
        int k;
        pick = r[0] ? 0 : 5;
        for (int j = 3; j >= 0; j--)
        begin
            k = ((s + j) % 4) + 1;
            if (r[k] && !r[0])
                pick = k;
        end
    endfunction

    // Group 2 holds lines 10..15, fed by single causes 27..32
    function automatic logic [55:0] g2(input logic [5:0] r);
        g2 = {23'h0, r, 27'h0};
    endfunction

    // One full service: request, check winner, clear latch then winner
    task serve(input logic [55:0] c, input logic [31:0] idx);
        cause_in <= c;
        repeat (8) @(posedge mclk);
        #1;
        chk("normal_req", {31'h0, normal_req}, 32'h1);
        rd(`RPIC_ADR_WIDX, idx, "winner_index");
        rd(`RPIC_ADR_WPEND, 32'h1 << idx, "winner_pending");
        cause_in <= '0;
        repeat (4) @(posedge mclk);
        wr(`RPIC_ADR_LATCH, 32'hFFFFFFFF);
        wr(`RPIC_ADR_WPEND, 32'hFFFFFFFF);
        repeat (4) @(posedge mclk);
        #1;
        chk("normal_req", {31'h0, normal_req}, 32'h0);
    endtask

    task reset_values();
        rd(`RPIC_ADR_LATCH, 32'h0, "latch");
        rd(`RPIC_ADR_MODE, 32'h0, "mode");
        rd(`RPIC_ADR_MASK, 32'hFFFFFFFF, "mask");
        rd(`RPIC_ADR_PRIO, 32'h0, "priority");
        rd(`RPIC_ADR_WPEND, 32'h0, "winner_pending");
        rd(`RPIC_ADR_WIDX, 32'h0, "winner_index");
    endtask

    task masked_latch();
        cause_in <= 56'h3;
        repeat (6) @(posedge mclk);
        cause_in <= '0;
        repeat (4) @(posedge mclk);
        rd(`RPIC_ADR_LATCH, 32'h3, "latch");
        rd(`RPIC_ADR_WPEND, 32'h0, "winner_pending");
        chk("normal_req", {31'h0, normal_req}, 32'h0);
        wr(`RPIC_ADR_LATCH, 32'h1);
        rd(`RPIC_ADR_LATCH, 32'h2, "latch");
        wr(`RPIC_ADR_LATCH, 32'h2);
        wr(`RPIC_ADR_WIDX, 32'h1F);
        rd(`RPIC_ADR_WIDX, 32'h0, "winner_index");
        rd(32'h4A000018, 32'h0, "unmapped");
    endtask

    // Short pulse; the latch must carry it after the cause is gone
    task normal_path();
        wr(`RPIC_ADR_MASK, 32'h0);
        cause_in <= 56'h8;
        repeat (2) @(posedge mclk);
        cause_in <= '0;
        repeat (8) @(posedge mclk);
        rd(`RPIC_ADR_LATCH, 32'h8, "latch");
        rd(`RPIC_ADR_WPEND, 32'h8, "winner_pending");
        wr(`RPIC_ADR_WPEND, 32'h8);
        repeat (4) @(posedge mclk);
        rd(`RPIC_ADR_WPEND, 32'h8, "winner_pending");
        wr(`RPIC_ADR_LATCH, 32'h8);
        wr(`RPIC_ADR_WPEND, 32'h8);
        repeat (4) @(posedge mclk);
        rd(`RPIC_ADR_WPEND, 32'h0, "winner_pending");
    endtask

    // Strobes while the enable is low must be ignored
    task ce_freeze();
        ce <= 1'b0;
        wr(`RPIC_ADR_MASK, 32'hFFFFFFFF);
        ce <= 1'b1;
        rd(`RPIC_ADR_MASK, 32'h0, "mask_frozen");
    endtask

    task fast_path();
        wr(`RPIC_ADR_MODE, 32'h4);
        cause_in <= 56'h4;
        repeat (8) @(posedge mclk);
        #1;
        chk("fast_req", {31'h0, fast_req}, 32'h1);
        chk("normal_req", {31'h0, normal_req}, 32'h0);
        chk("core_fast", {24'h0, fast_cnt}, 32'h1);
        rd(`RPIC_ADR_WPEND, 32'h0, "winner_pending");
        cause_in <= '0;
        repeat (4) @(posedge mclk);
        wr(`RPIC_ADR_LATCH, 32'hFFFFFFFF);
        repeat (3) @(posedge mclk);
        #1;
        chk("fast_req", {31'h0, fast_req}, 32'h0);
        wr(`RPIC_ADR_MODE, 32'h0);
    endtask

    // Each service is one normal request seen by the core
    task groups();
        logic [7:0] n0;
        n0 = normal_cnt;
        serve(56'h8 | g2(6'h01), 32'd3);
        serve((56'h1 << 49) | g2(6'h02), 32'd11);
        serve(56'h1 << 54, 32'd31);
        chk("core_normal", {24'h0, normal_cnt}, {24'h0, n0 + 8'h03});
    endtask

    // Rotation off: select must only change by software writes
    task fixed_prio();
        for (int s = 0; s < 4; s++)
        begin
            wr(`RPIC_ADR_PRIO, 32'(s) << 11);
            serve(g2(6'h3E), 32'(10 + pick(6'h3E, 2'(s))));
            serve(g2(6'h3F), 32'd10);
            rd(`RPIC_ADR_PRIO, 32'(s) << 11, "priority");
        end
    endtask

    // Rotation on for group 2 and the second level
    task rotate_prio();
        logic [1:0] s;
        int k;
        s = 2'h0;
        wr(`RPIC_ADR_PRIO, 32'h44);
        for (int i = 0; i < 4; i++)
        begin
            k = pick(6'h1E, s);
            serve(g2(6'h1E), 32'(10 + k));
            s = 2'(k % 4);
            rd(`RPIC_ADR_PRIO, 32'h100044 | (32'(s) << 11), "priority");
        end
        serve(g2(6'h01), 32'd10);
        serve(g2(6'h20), 32'd15);
        rd(`RPIC_ADR_PRIO, 32'h100044, "priority");
        wr(`RPIC_ADR_PRIO, 32'h0);
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        reset_values();
        masked_latch();
        normal_path();
        fast_path();
        ce_freeze();
        groups();
        fixed_prio();
        rotate_prio();
        complete_run();
    end

    // Watchdog, far beyond the expected run of about 550 cycles
    initial
    begin
        #800000;
        error_cnt++;
        complete_run();
    end
endmodule
